// >>> design/xmd_engine.sv
`default_nettype none
// Overview of operation
// - mode a fields at bits 7..0
// - source step fixed or increments by unit
// - source step code 11 decrements by unit
// - destination step fixed or increments by unit
// - destination step code 11 decrements by unit
// - kinds normal, repeat, block; 11 prohibited
// - side select picks repeat or block area
// - unit size picks byte or word
// - chain enable loads next set, same activation
// - chained set: no end check, no clears
// - irq every transfer keeps source flag set
// - otherwise irq only at count end
// - mode b low six bits ignored
// - load set from ram, write back after
// - normal: 16-bit count down to zero
// - repeat/block: low byte reloads from high
module xmd_engine (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic act_valid,
	input wire logic [xmd_pkg::VEC_W-1:0] act_vec,
	output logic act_ack,
	output logic ram_rd_req,
	output logic [xmd_pkg::VEC_W-1:0] ram_addr,
	input wire logic ram_rd_valid,
	input wire xmd_pkg::xmd_set_type ram_rd_data,
	output logic ram_wr_valid,
	output xmd_pkg::xmd_set_type ram_wr_data,
	output logic move_valid,
	output xmd_pkg::xmd_move_type move_data,
	input wire logic move_ready,
	output logic irq_req,
	output logic clear_flag,
	output logic clear_enable,
	output logic bad_kind
);
	typedef enum {ST_IDLE, ST_LOAD, ST_XFER, ST_STORE, ST_DONE} xmd_state_type;
	xmd_state_type state;
	xmd_pkg::xmd_set_type set;
	xmd_pkg::xmd_set_type next_set;
	logic ended;
	logic next_ended;
	logic more;
	logic chain;
	logic [1:0] kind;
	logic [xmd_pkg::PTR_W-1:0] src_delta;
	logic [xmd_pkg::PTR_W-1:0] dst_delta;
	logic [7:0] low_next;
	logic reload;
	logic [xmd_pkg::PTR_W-1:0] rewind;
	logic src_area;
	logic push;
	logic pop;
	logic full;
	xmd_pkg::xmd_move_type slot1;
	logic vld1;

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// pointer step for a code and unit size
	function automatic logic [xmd_pkg::PTR_W-1:0] step_of(input logic [1:0] code,
			input logic word);
		logic [xmd_pkg::PTR_W-1:0] mag;
		mag = word ? 24'h000002 : 24'h000001;
		if (!code[1]) begin
			step_of = 24'h000000;
		end else if (code == xmd_pkg::STEP_DEC) begin
			step_of = 24'(~mag + 24'h000001);
		end else begin
			step_of = mag;
		end
	endfunction

	// field decode of the loaded set
	always_comb begin
		kind = set.transfer_mode_a[xmd_pkg::OP_KIND_HI:xmd_pkg::OP_KIND_LO];
		if (kind == 2'h3) begin
			kind = xmd_pkg::OP_NORMAL;
		end
		src_delta = step_of(set.transfer_mode_a[xmd_pkg::SRC_STEP_HI:xmd_pkg::SRC_STEP_LO],
			set.transfer_mode_a[xmd_pkg::UNIT_SIZE]);
		dst_delta = step_of(set.transfer_mode_a[xmd_pkg::DST_STEP_HI:xmd_pkg::DST_STEP_LO],
			set.transfer_mode_a[xmd_pkg::UNIT_SIZE]);
		src_area = set.transfer_mode_a[xmd_pkg::AREA_SIDE_SELECT];
		chain = set.transfer_mode_b[xmd_pkg::CHAIN_ENABLE];
	end

	// counts and pointers after one unit; area rewinds on reload
	always_comb begin
		next_set = set;
		next_ended = 1'b0;
		more = 1'b0;
		next_set.src_pointer = 24'(set.src_pointer + src_delta);
		next_set.dst_pointer = 24'(set.dst_pointer + dst_delta);
		low_next = 8'(set.count_a[7:0] - 8'h01);
		reload = 1'b0;
		// a high byte of zero stands for 256 units
		rewind = 24'(24'({set.count_a[15:8] == 8'h00, set.count_a[15:8]})
			* (src_area ? src_delta : dst_delta));
		if (kind == xmd_pkg::OP_NORMAL) begin
			next_set.count_a = 16'(set.count_a - 16'h0001);
			next_ended = next_set.count_a == 16'h0000;
		end else begin
			next_set.count_a[7:0] = low_next;
			reload = low_next == 8'h00;
			if (reload) begin
				next_set.count_a[7:0] = set.count_a[15:8];
				if (src_area) begin
					next_set.src_pointer = 24'(next_set.src_pointer - rewind);
				end else begin
					next_set.dst_pointer = 24'(next_set.dst_pointer - rewind);
				end
			end
			if (kind == xmd_pkg::OP_BLOCK) begin
				more = !reload;
				if (reload) begin
					next_set.count_b = 16'(set.count_b - 16'h0001);
					next_ended = next_set.count_b == 16'h0000;
				end
			end
		end
		if (chain) begin
			next_ended = 1'b0;
		end
	end

	assign push = ce && state == ST_XFER && !full;
	assign pop = ce && move_valid && move_ready;
	assign full = vld1;

	// main sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			set <= '0;
			ended <= 1'b0;
			ram_addr <= '0;
		end else if (ce) begin
			case (state)
				ST_IDLE: begin
					if (act_valid) begin
						ram_addr <= act_vec;
						state <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (ram_rd_valid) begin
						set <= ram_rd_data;
						state <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (!full) begin
						set <= next_set;
						ended <= next_ended;
						state <= more ? ST_XFER : ST_STORE;
					end
				end
				ST_STORE: begin
					state <= ST_DONE;
				end
				ST_DONE: begin
					if (chain) begin
						ram_addr <= 8'(ram_addr + 8'h01);
						state <= ST_LOAD;
					end else begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ram handshake strobes, one cycle each
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			act_ack <= 1'b0;
			ram_rd_req <= 1'b0;
			ram_wr_valid <= 1'b0;
			ram_wr_data <= '0;
		end else if (ce) begin
			act_ack <= state == ST_IDLE && act_valid;
			ram_rd_req <= (state == ST_IDLE && act_valid) || (state == ST_DONE && chain);
			ram_wr_valid <= state == ST_STORE;
			if (state == ST_STORE) begin
				ram_wr_data <= set;
			end
		end
	end

	// end-of-set outcome: irq, flag clear, enable clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq_req <= 1'b0;
			clear_flag <= 1'b0;
			clear_enable <= 1'b0;
		end else if (ce) begin
			irq_req <= 1'b0;
			clear_flag <= 1'b0;
			clear_enable <= 1'b0;
			if (state == ST_DONE && !chain) begin
				irq_req <= set.transfer_mode_b[xmd_pkg::IRQ_EVERY_TRANSFER] || ended;
				clear_flag <= !set.transfer_mode_b[xmd_pkg::IRQ_EVERY_TRANSFER] && !ended;
				clear_enable <= set.transfer_mode_b[xmd_pkg::IRQ_EVERY_TRANSFER] || ended;
			end
		end
	end

	// prohibited kind seen at load time
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bad_kind <= 1'b0;
		end else if (ce && state == ST_LOAD && ram_rd_valid) begin
			bad_kind <= ram_rd_data.transfer_mode_a[xmd_pkg::OP_KIND_HI:xmd_pkg::OP_KIND_LO]
				== 2'h3;
		end
	end

	// two-entry move buffer; head slot drives the port so a stalled mover loses nothing
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			move_valid <= 1'b0;
			vld1 <= 1'b0;
			move_data <= '0;
			slot1 <= '0;
		end else if (ce) begin
			if (pop) begin
				move_valid <= vld1 || push;
				move_data <= vld1 ? slot1 : {set.src_pointer, set.dst_pointer,
					set.transfer_mode_a[xmd_pkg::UNIT_SIZE]};
				vld1 <= vld1 && push;
				if (push) begin
					slot1 <= {set.src_pointer, set.dst_pointer,
						set.transfer_mode_a[xmd_pkg::UNIT_SIZE]};
				end
			end else if (push) begin
				if (!move_valid) begin
					move_valid <= 1'b1;
					move_data <= {set.src_pointer, set.dst_pointer,
						set.transfer_mode_a[xmd_pkg::UNIT_SIZE]};
				end else begin
					vld1 <= 1'b1;
					slot1 <= {set.src_pointer, set.dst_pointer,
						set.transfer_mode_a[xmd_pkg::UNIT_SIZE]};
				end
			end
		end
	end

	normal_count_a: assert property (ce && push && kind == xmd_pkg::OP_NORMAL && !chain
		|=> ended == (set.count_a == 16'h0000)) else $error("normal end mismatch");
	low_reload_a: assert property (ce && push && kind != xmd_pkg::OP_NORMAL
		&& set.count_a[7:0] == 8'h01 |=> set.count_a[7:0] == set.count_a[15:8])
		else $error("low byte not reloaded");
	src_inc_a: assert property (ce && push && kind == xmd_pkg::OP_NORMAL
		&& set.transfer_mode_a[7:6] == 2'h2 |=> set.src_pointer
		== 24'($past(set.src_pointer) + ($past(set.transfer_mode_a[0]) ? 24'h2 : 24'h1)))
		else $error("source step wrong");
	dst_dec_a: assert property (ce && push && kind == xmd_pkg::OP_NORMAL
		&& set.transfer_mode_a[5:4] == 2'h3 |=> set.dst_pointer
		== 24'($past(set.dst_pointer) - ($past(set.transfer_mode_a[0]) ? 24'h2 : 24'h1)))
		else $error("destination step wrong");
	chain_quiet_a: assert property (ce && state == ST_DONE && chain
		|=> !irq_req && !clear_flag && !clear_enable && ram_rd_req)
		else $error("chain did clear or skip load");
	irq_every_a: assert property (ce && state == ST_DONE && !chain
		&& set.transfer_mode_b[6] |=> irq_req && !clear_flag)
		else $error("per-transfer irq missing");
	irq_end_a: assert property (ce && state == ST_DONE && !chain
		&& !set.transfer_mode_b[6] |=> irq_req == ended)
		else $error("count-end irq wrong");
	write_back_a: assert property (ce && state == ST_STORE |=> ram_wr_valid
		&& ram_wr_data == $past(set)) else $error("set not written back");
	flag_pair_a: assert property (!(clear_flag && irq_req))
		else $error("flag cleared with irq");
	mode_b_low_a: assert property (ce && state == ST_LOAD && ram_rd_valid
		##1 ce ##0 state == ST_XFER |-> chain == set.transfer_mode_b[7])
		else $error("mode b decode wrong");

	chain_cov: cover property (ce && state == ST_DONE && chain);
	block_cov: cover property (ce && push && kind == xmd_pkg::OP_BLOCK && reload);
	stall_cov: cover property (ce && state == ST_XFER && full);
	end_cov: cover property (irq_req && clear_enable);
endmodule // xmd_engine
`default_nettype wire

// >>> shared/xmd_pkg.sv
`default_nettype none
package xmd_pkg;
	// first mode register layout
	localparam int SRC_STEP_HI = 7;
	localparam int SRC_STEP_LO = 6;
	localparam int DST_STEP_HI = 5;
	localparam int DST_STEP_LO = 4;
	localparam int OP_KIND_HI = 3;
	localparam int OP_KIND_LO = 2;
	localparam int AREA_SIDE_SELECT = 1;
	localparam int UNIT_SIZE = 0;
	// second mode register layout
	localparam int CHAIN_ENABLE = 7;
	localparam int IRQ_EVERY_TRANSFER = 6;
	localparam logic [7:0] MODE_B_USED = 8'hc0;
	// step codes
	localparam logic [1:0] STEP_INC = 2'h2;
	localparam logic [1:0] STEP_DEC = 2'h3;
	// operation kinds
	localparam logic [1:0] OP_NORMAL = 2'h0;
	localparam logic [1:0] OP_REPEAT = 2'h1;
	localparam logic [1:0] OP_BLOCK = 2'h2;
	localparam int PTR_W = 24;
	localparam int VEC_W = 8;
	// register set image as held in on-chip ram
	typedef struct packed {
		logic [7:0] transfer_mode_a;
		logic [7:0] transfer_mode_b;
		logic [PTR_W-1:0] src_pointer;
		logic [PTR_W-1:0] dst_pointer;
		logic [15:0] count_a;
		logic [15:0] count_b;
	} xmd_set_type;
	// one unit move for the bus mover
	typedef struct packed {
		logic [PTR_W-1:0] src;
		logic [PTR_W-1:0] dst;
		logic word;
	} xmd_move_type;
endpackage
`default_nettype wire

// >>> dv/xmd_ram_model.sv
`default_nettype none
// far side: register image ram and a slow unit mover
module xmd_ram_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ram_rd_req,
	input wire logic [xmd_pkg::VEC_W-1:0] ram_addr,
	output logic ram_rd_valid,
	output xmd_pkg::xmd_set_type ram_rd_data,
	input wire logic ram_wr_valid,
	input wire xmd_pkg::xmd_set_type ram_wr_data,
	input wire logic move_valid,
	input wire xmd_pkg::xmd_move_type move_data,
	output logic move_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	xmd_pkg::xmd_set_type mem [256];
	xmd_pkg::xmd_move_type moves [$];
	int wr_cnt = 0;
	int dly = 0;
	logic [1:0] stall = 2'h0;
	// watch on the falling edge, where the engine's registers are settled
	always @(negedge clk) begin
		// only this process owns the read countdown
		if (ram_rd_req) begin
			dly = 2;
		end else if (dly > 0) begin
			dly = dly - 1;
		end
		if (ram_wr_valid) begin
			mem[ram_addr] = ram_wr_data;
			wr_cnt++;
		end
		if (move_valid && move_ready) begin
			moves.push_back(move_data);
		end
	end
	// drive after the rising edge; idle data scrambles so stale values never pass
	always @(posedge clk) begin
		#1;
		ram_rd_valid = (dly == 1) && !sys_rst;
		ram_rd_data = ram_rd_valid ? mem[ram_addr] : ~ram_rd_data;
		stall = stall + 2'h1;
		move_ready = (stall == 2'h3); // one in four, so the buffer fills
	end
	initial begin
		ram_rd_valid = 1'b0;
		ram_rd_data = '0;
		move_ready = 1'b0;
	end
endmodule // xmd_ram_model
`default_nettype wire

// >>> dv/test_xmd_engine.sv
`default_nettype none
module test_xmd_engine;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, sys_rst, ce, act_valid, act_ack, ram_rd_req, ram_rd_valid, ram_wr_valid;
	logic move_valid, move_ready, irq_req, clear_flag, clear_enable, bad_kind;
	logic [xmd_pkg::VEC_W-1:0] act_vec, ram_addr;
	xmd_pkg::xmd_set_type ram_rd_data, ram_wr_data;
	xmd_pkg::xmd_move_type move_data;
	logic [2:0] seen;
	int mismatches = 0;
	int cmp_count = 0;
	xmd_engine xmd_engine_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce), .act_valid(act_valid),
		.act_vec(act_vec), .act_ack(act_ack), .ram_rd_req(ram_rd_req), .ram_addr(ram_addr),
		.ram_rd_valid(ram_rd_valid), .ram_rd_data(ram_rd_data), .ram_wr_valid(ram_wr_valid),
		.ram_wr_data(ram_wr_data), .move_valid(move_valid), .move_data(move_data),
		.move_ready(move_ready), .irq_req(irq_req), .clear_flag(clear_flag),
		.clear_enable(clear_enable), .bad_kind(bad_kind));
	xmd_ram_model xmd_ram_model_inst (.clk(clk), .sys_rst(sys_rst), .ram_rd_req(ram_rd_req),
		.ram_addr(ram_addr), .ram_rd_valid(ram_rd_valid), .ram_rd_data(ram_rd_data),
		.ram_wr_valid(ram_wr_valid), .ram_wr_data(ram_wr_data), .move_valid(move_valid),
		.move_data(move_data), .move_ready(move_ready));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// outcome pulses last one cycle, so gather {irq, flag, enable} per activation
	always @(negedge clk) seen = seen | {irq_req, clear_flag, clear_enable};
	task automatic check(input logic [95:0] got, input logic [95:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// hold the request through the acknowledge, then wait for the write-backs
	task automatic activate(input logic [7:0] vec, input int sets);
		int i;
		int n;
		i = 0;
		n = xmd_ram_model_inst.wr_cnt + sets;
		seen = 3'h0;
		xmd_ram_model_inst.moves.delete();
		act_vec = vec;
		act_valid = 1'b1;
		do begin
			@(posedge clk);
			#1;
			i++;
		end while (act_ack !== 1'b1 && i < 100);
		@(posedge clk);
		#1;
		act_valid = 1'b0;
		while (xmd_ram_model_inst.wr_cnt < n && i < 400) begin
			@(posedge clk);
			#1;
			i++;
		end
		// a slow mover may still be draining two buffered units after the write-back
		repeat (8) @(posedge clk);
		#1;
		check(96'(i < 400), 96'h1);
	endtask
	// one set: image after write-back, pulses, move count and first move
	task automatic run_case(input logic [7:0] vec, input logic [95:0] s,
		input logic [95:0] e, input logic [2:0] es, input int nm);
		xmd_ram_model_inst.mem[vec] = s;
		activate(vec, 1);
		check(xmd_ram_model_inst.mem[vec], e);
		check(96'(seen), 96'(es));
		check(96'(xmd_ram_model_inst.moves.size()), 96'(nm));
		check(96'(xmd_ram_model_inst.moves[0]), 96'({s[79:32], s[88]}));
		$display("test at set %h done", vec);
	endtask
	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		act_valid = 1'b0;
		act_vec = 8'h00;
		seen = 3'h0;
		repeat (16) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		check(96'({act_ack, ram_rd_req, ram_wr_valid, move_valid, irq_req}), 96'h0);
		run_case(8'h10, {8'hb0, 8'h00, 24'h000100, 24'h000200, 16'h0001, 16'h0000},
			{8'hb0, 8'h00, 24'h000101, 24'h0001ff, 16'h0000, 16'h0000}, 3'h5, 1);
		check(96'(bad_kind), 96'h0);
		run_case(8'h11, {8'he1, 8'h7f, 24'h000100, 24'h000200, 16'h0005, 16'h0000},
			{8'he1, 8'h7f, 24'h0000fe, 24'h000202, 16'h0004, 16'h0000}, 3'h5, 1);
		run_case(8'h12, {8'hc7, 8'h00, 24'h000300, 24'h000400, 16'h0301, 16'h0000},
			{8'hc7, 8'h00, 24'h000304, 24'h000400, 16'h0303, 16'h0000}, 3'h2, 1);
		run_case(8'h13, {8'h88, 8'h00, 24'h000500, 24'h000600, 16'h0202, 16'h0001},
			{8'h88, 8'h00, 24'h000502, 24'h000600, 16'h0202, 16'h0000}, 3'h5, 2);
		run_case(8'h14, {8'h0c, 8'h00, 24'h000700, 24'h000800, 16'h0003, 16'h0000},
			{8'h0c, 8'h00, 24'h000700, 24'h000800, 16'h0002, 16'h0000}, 3'h2, 1);
		check(96'(bad_kind), 96'h1);
		// chained pair: first set must not end or clear anything
		xmd_ram_model_inst.mem[8'h20] = {8'h80, 8'h80, 24'h000900, 24'h000a00, 16'h0001, 16'h0};
		xmd_ram_model_inst.mem[8'h21] = {8'h20, 8'h00, 24'h000b00, 24'h000c00, 16'h0002, 16'h0};
		activate(8'h20, 2);
		check(xmd_ram_model_inst.mem[8'h20], {8'h80, 8'h80, 24'h901, 24'ha00, 32'h0});
		check(xmd_ram_model_inst.mem[8'h21], {8'h20, 8'h00, 24'hb00, 24'hc01, 32'h00010000});
		check(96'(seen), 96'h2);
		$display("test chain done");
		close_out();
	end
	// watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#100000;
		mismatches++;
		close_out();
	end
endmodule // test_xmd_engine
`default_nettype wire
